// File: rtl/serial_channel_control_regs.svh
// register offsets, field positions and reset values of the serial channel control block
//
// Behaviour
// - writing 1 to a clear bit clears that channel's matching error flag; 0 leaves it
// - flag clear register of each channel always reads zero
// - channel 0 clears only overrun at bit 0; channel 1 adds framing, parity, biphase
// - start trigger sets enable state and enters wait; trigger self-clears
// - start during transfer suspends it, holding registers, pin levels and error flags
// - start and stop trigger registers always read zero
// - stop trigger clears enable state, stops channel, holds values; trigger self-clears
// - enable state reads 1 when enabled; changed only by start and stop triggers
// - with output enable 1, pin follows transfer data and value bit writes are ignored
// - with output enable 0, value bit is writable and drives the pin directly
// - output value register resets to 0303, bits 9,8,1 stay one, bit 0 holds the value bit, others zero
// - invert applies only while output enabled; disabled output shows value bit as is
// - wake bit 1 lets a reception start in stop mode run the receiver
// - error select 0 lets the standby reception error interrupt through, 1 blocks it
// - clock request drops on wake clear or false start; also on errors when select is 1
`ifndef SERIAL_CHANNEL_CONTROL_REGS_SVH
`define SERIAL_CHANNEL_CONTROL_REGS_SVH

`define ADDR_START_TRIG    20'hF05A2
`define ADDR_STOP_TRIG     20'hF05A4
`define ADDR_ENABLE_STATE  20'hF05A6
`define ADDR_OUT_ENABLE    20'hF05AA
`define ADDR_OUT_VALUE     20'hF05AC
`define ADDR_OUT_INVERT    20'hF05AE
`define ADDR_STANDBY_CTRL  20'hF05B8
`define ADDR_FLAG_CLEAR0   20'hF0588
`define ADDR_FLAG_CLEAR1   20'hF058A

`define BIT_OVERRUN_CLR    0
`define BIT_PARITY_CLR     1
`define BIT_FRAME_CLR      2
`define BIT_BIPHASE_CLR    7
`define BIT_WAKE_EN        0
`define BIT_ERR_IRQ_STOP   1

`define RESET_OUT_VALUE    16'h0303
`define OUT_VALUE_FIXED1   16'h0302
`define RESET_ZERO         16'h0000

`endif

// File: rtl/serial_channel_control_pkg.sv
// types shared by the serial channel control block
package serial_channel_control_pkg;

	typedef enum logic [1:0] {
		CH_STOPPED = 2'b00,
		CH_WAIT    = 2'b01,
		CH_ACTIVE  = 2'b10
	} chan_state_t;

	// per channel error flags
	typedef struct packed {
		logic biphase;
		logic frame;
		logic parity;
		logic overrun;
	} err_flags_t;

	// engine events entering the block
	typedef struct packed {
		logic xfer_start;
		logic xfer_end;
		logic err_frame;
		logic err_parity;
		logic err_overrun;
		logic err_biphase;
	} chan_event_t;

	typedef struct packed {
		chan_state_t [1:0] st;
		err_flags_t  [1:0] err;
		logic        [1:0] enabled;
		logic              out_enable;
		logic              out_value;
		logic              out_invert;
		logic              wake_en;
		logic              err_irq_stop;
		logic              clk_req;
		logic              err_irq;
		logic              pin;
		logic              rx_s1;
		logic              rx_s2;
		logic              rx_s3;
		logic              stop_mode_s1;
		logic              stop_mode_s2;
		logic       [15:0] rdata;
	} ctrl_state_t;

endpackage

// File: rtl/serial_channel_control.sv
// channel control plane: triggers, enable state, error flag clears, output path, standby wake
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "serial_channel_control_regs.svh"

module serial_channel_control
	import serial_channel_control_pkg::*;
(
	input  wire logic        clk,            // 20 MHz system clock
	input  wire logic        reset_n,        // asynchronous reset, active low
	input  wire logic [19:0] addr,           // register address
	input  wire logic [15:0] wdata,          // write data
	input  wire logic        wr,             // write strobe
	input  wire logic        rd,             // read strobe
	output logic      [15:0] rdata,          // read data, cycle after rd
	input  wire chan_event_t [1:0] ev,       // transfer engine events per channel
	input  wire logic        tx_data,        // channel 0 engine transmit bit
	input  wire logic        rx_pin,         // serial receive pin, asynchronous
	input  wire logic        stop_mode,      // device in stop mode, asynchronous
	input  wire logic        false_start,    // receiver saw a false start bit
	output logic      [1:0]  chan_enabled,   // enable state per channel
	output logic      [1:0]  chan_running,   // channel in transfer
	output err_flags_t [1:0] err_flags,      // error flags per channel
	output logic             bus_transmit_pin, // serial output pin
	output logic             rx_wake,        // receiver start without cpu
	output logic             clk_req,        // clock request to clock generator
	output logic             rx_error_irq    // standby reception error interrupt
);

	ctrl_state_t s_q;
	ctrl_state_t s_d;

	// address matches a given register address
	function automatic logic hit(input logic [19:0] a, input logic [19:0] ref_a);
		hit = (a == ref_a);
	endfunction

	logic wr_start;
	logic wr_stop;
	logic wr_clr0;
	logic wr_clr1;
	logic rx_fall;

	assign wr_start = wr && hit(addr, `ADDR_START_TRIG);
	assign wr_stop  = wr && hit(addr, `ADDR_STOP_TRIG);
	assign wr_clr0  = wr && hit(addr, `ADDR_FLAG_CLEAR0);
	assign wr_clr1  = wr && hit(addr, `ADDR_FLAG_CLEAR1);
	// start edge seen on synchronised samples only
	assign rx_fall  = s_q.rx_s3 && !s_q.rx_s2;

	// next state of the whole block
	always_comb begin
		s_d = s_q;
		s_d.rx_s1        = rx_pin;
		s_d.rx_s2        = s_q.rx_s1;
		s_d.rx_s3        = s_q.rx_s2;
		s_d.stop_mode_s1 = stop_mode;
		s_d.stop_mode_s2 = s_q.stop_mode_s1;
		s_d.err_irq      = 1'b0;
		s_d.rdata        = 16'h0000;

		for (int n = 0; n < 2; n++) begin
			// engine events: the triggers below override them
			if (s_q.enabled[n] && ev[n].xfer_start) begin
				s_d.st[n] = CH_ACTIVE;
			end
			if (ev[n].xfer_end && s_q.st[n] == CH_ACTIVE) begin
				s_d.st[n] = CH_WAIT;
			end
			// triggers act in the cycle of the write; nothing is stored, so they self-clear
			if (wr_start && wdata[n]) begin
				s_d.enabled[n] = 1'b1;
				s_d.st[n]      = CH_WAIT;
			end
			if (wr_stop && wdata[n]) begin
				s_d.enabled[n] = 1'b0;
				s_d.st[n]      = CH_STOPPED;
			end
		end

		// error flag clears, then engine sets override them
		if (wr_clr0 && wdata[`BIT_OVERRUN_CLR]) begin
			s_d.err[0].overrun = 1'b0;
		end
		if (wr_clr1) begin
			if (wdata[`BIT_OVERRUN_CLR]) s_d.err[1].overrun = 1'b0;
			if (wdata[`BIT_PARITY_CLR])  s_d.err[1].parity  = 1'b0;
			if (wdata[`BIT_FRAME_CLR])   s_d.err[1].frame   = 1'b0;
			if (wdata[`BIT_BIPHASE_CLR]) s_d.err[1].biphase = 1'b0;
		end
		// channel 0 holds only an overrun flag
		if (ev[0].err_overrun) s_d.err[0].overrun = 1'b1;
		if (ev[1].err_overrun) s_d.err[1].overrun = 1'b1;
		if (ev[1].err_parity)  s_d.err[1].parity  = 1'b1;
		if (ev[1].err_frame)   s_d.err[1].frame   = 1'b1;
		if (ev[1].err_biphase) s_d.err[1].biphase = 1'b1;

		// plain control registers
		if (wr && hit(addr, `ADDR_OUT_ENABLE)) begin
			s_d.out_enable = wdata[0];
		end
		// software writes to the value bit ignored while the engine owns the pin
		if (wr && hit(addr, `ADDR_OUT_VALUE) && !s_q.out_enable) begin
			s_d.out_value = wdata[0];
		end
		if (s_q.out_enable) begin
			s_d.out_value = tx_data;
		end
		// software is expected not to touch invert while enabled; not blocked here
		if (wr && hit(addr, `ADDR_OUT_INVERT)) begin
			s_d.out_invert = wdata[0];
		end
		if (wr && hit(addr, `ADDR_STANDBY_CTRL)) begin
			s_d.wake_en      = wdata[`BIT_WAKE_EN];
			s_d.err_irq_stop = wdata[`BIT_ERR_IRQ_STOP];
		end

		// pin: invert only on engine data
		s_d.pin = s_d.out_enable ? (s_d.out_value ^ s_d.out_invert) : s_d.out_value;

		// standby wake: start edge in stop mode raises the clock request
		if (s_q.wake_en && s_q.stop_mode_s2 && rx_fall) begin
			s_d.clk_req = 1'b1;
		end
		if (s_q.clk_req && (ev[1].err_parity || ev[1].err_frame)) begin
			s_d.err_irq = !s_q.err_irq_stop;
			if (s_q.err_irq_stop) begin
				s_d.clk_req = 1'b0;
			end
		end
		if (!s_d.wake_en || false_start) begin
			s_d.clk_req = 1'b0;
		end

		// read data the cycle after rd; trigger registers read zero
		if (rd) begin
			if (hit(addr, `ADDR_ENABLE_STATE)) begin
				s_d.rdata = {14'h0000, s_q.enabled};
			end else if (hit(addr, `ADDR_OUT_ENABLE)) begin
				s_d.rdata = {15'h0000, s_q.out_enable};
			end else if (hit(addr, `ADDR_OUT_VALUE)) begin
				s_d.rdata = `OUT_VALUE_FIXED1 | {15'h0000, s_q.out_value};
			end else if (hit(addr, `ADDR_OUT_INVERT)) begin
				s_d.rdata = {15'h0000, s_q.out_invert};
			end else if (hit(addr, `ADDR_STANDBY_CTRL)) begin
				s_d.rdata = {14'h0000, s_q.err_irq_stop, s_q.wake_en};
			end else begin
				s_d.rdata = `RESET_ZERO;
			end
		end
	end

	// single state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.out_value <= 1'b1;
			s_q.pin       <= 1'b1;
			s_q.rx_s1     <= 1'b1;
			s_q.rx_s2     <= 1'b1;
			s_q.rx_s3     <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata            = s_q.rdata;
	assign chan_enabled     = s_q.enabled;
	// only the active code has its upper bit set, so that flop bit is the running flag
	assign chan_running     = {s_q.st[1][1], s_q.st[0][1]};
	assign err_flags        = s_q.err;
	assign bus_transmit_pin = s_q.pin;
	assign rx_wake          = s_q.clk_req;
	assign clk_req          = s_q.clk_req;
	assign rx_error_irq     = s_q.err_irq;

	// start write shows enabled on the next edge
	AST_START_SETS: assert property (@(posedge clk) disable iff (!reset_n)
		wr_start && wdata[0] && !(wr_stop) |=> chan_enabled[0])
		else $error("start trigger did not enable channel 0");
	AST_STOP_CLEARS: assert property (@(posedge clk) disable iff (!reset_n)
		wr_stop && wdata[1] |=> !chan_enabled[1])
		else $error("stop trigger did not stop channel 1");
	AST_ENABLE_ONLY_TRIG: assert property (@(posedge clk) disable iff (!reset_n)
		!(wr_start || wr_stop) |=> $stable(chan_enabled))
		else $error("enable state changed without trigger");
	AST_CLEAR_OVERRUN: assert property (@(posedge clk) disable iff (!reset_n)
		wr_clr1 && wdata[0] && !ev[1].err_overrun |=> !err_flags[1].overrun)
		else $error("overrun flag not cleared");
	AST_TRIG_READ_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
		rd && (hit(addr, `ADDR_START_TRIG) || hit(addr, `ADDR_FLAG_CLEAR0)) |=> rdata == 16'h0000)
		else $error("trigger register read not zero");
	AST_VALUE_LOCKED: assert property (@(posedge clk) disable iff (!reset_n)
		s_q.out_enable && $past(s_q.out_enable) |-> s_q.out_value == $past(tx_data))
		else $error("value bit not from engine while enabled");
	AST_PIN_PLAIN: assert property (@(posedge clk) disable iff (!reset_n)
		!s_q.out_enable |-> bus_transmit_pin == s_q.out_value)
		else $error("pin inverted while output disabled");
	AST_CLKREQ_DROP: assert property (@(posedge clk) disable iff (!reset_n)
		false_start |=> !clk_req)
		else $error("clock request held after false start");

	// standby control written this cycle
	logic wr_standby;
	assign wr_standby = wr && hit(addr, `ADDR_STANDBY_CTRL);

	// start edge on the line while asleep with wake enabled
	sequence seq_wake_edge;
		s_q.wake_en && s_q.stop_mode_s2 && rx_fall;
	endsequence

	// nothing in the same cycle pulls the request down again
	sequence seq_no_drop;
		!false_start && !wr_standby && !(s_q.err_irq_stop && (ev[1].err_parity || ev[1].err_frame));
	endsequence

	// parity or framing error ending a standby reception
	sequence seq_standby_err;
		clk_req && (ev[1].err_parity || ev[1].err_frame);
	endsequence

	// a start edge in stop mode wakes the receiver on the next edge
	AST_WAKE_RAISE: assert property (@(posedge clk) disable iff (!reset_n)
		seq_wake_edge ##0 seq_no_drop |=> clk_req)
		else $error("start edge in stop mode did not raise the clock request");

	// error select low lets the standby error interrupt out
	AST_IRQ_ALLOW: assert property (@(posedge clk) disable iff (!reset_n)
		seq_standby_err ##0 !s_q.err_irq_stop |=> rx_error_irq)
		else $error("standby error interrupt missing");

	// error select high blocks the interrupt whatever happens
	AST_IRQ_BLOCK: assert property (@(posedge clk) disable iff (!reset_n)
		s_q.err_irq_stop |=> !rx_error_irq)
		else $error("standby error interrupt not blocked");

	// the interrupt belongs to standby reception only
	AST_IRQ_QUIET: assert property (@(posedge clk) disable iff (!reset_n)
		!clk_req |=> !rx_error_irq)
		else $error("error interrupt outside standby reception");

	// with error select high an ending error also drops the request
	AST_ERR_DROP: assert property (@(posedge clk) disable iff (!reset_n)
		seq_standby_err ##0 s_q.err_irq_stop |=> !clk_req)
		else $error("clock request held after reception error");

	// clearing the wake bit drops the request at once
	AST_WAKE_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
		wr_standby && !wdata[`BIT_WAKE_EN] |=> !clk_req)
		else $error("clock request held after wake bit clear");

	// a request never outlives the wake bit
	AST_REQ_NEEDS_WAKE: assert property (@(posedge clk) disable iff (!reset_n)
		clk_req |-> s_q.wake_en)
		else $error("clock request without wake bit");

	// outside stop mode the line cannot raise a request
	AST_NO_WAKE_AWAKE: assert property (@(posedge clk) disable iff (!reset_n)
		!s_q.stop_mode_s2 && !clk_req |=> !clk_req)
		else $error("clock request raised outside stop mode");

	// an engine error sets its flag even beside a clear
	AST_FLAG_SET_WINS: assert property (@(posedge clk) disable iff (!reset_n)
		ev[1].err_frame |=> err_flags[1].frame)
		else $error("framing error flag not set");

	// a zero clear bit leaves its flag alone
	AST_CLEAR_ZERO_KEEPS: assert property (@(posedge clk) disable iff (!reset_n)
		wr_clr1 && !wdata[`BIT_PARITY_CLR] && !ev[1].err_parity |=> $stable(err_flags[1].parity))
		else $error("parity flag changed by a zero clear bit");

	// channel 0 overrun clear
	AST_CLEAR_CH0: assert property (@(posedge clk) disable iff (!reset_n)
		wr_clr0 && wdata[`BIT_OVERRUN_CLR] && !ev[0].err_overrun |=> !err_flags[0].overrun)
		else $error("channel 0 overrun flag not cleared");

	// channel 0 has no clears beyond overrun, so other bits do nothing
	AST_CH0_RESERVED: assert property (@(posedge clk) disable iff (!reset_n)
		wr_clr0 && !wdata[`BIT_OVERRUN_CLR] && !ev[0].err_overrun |=> $stable(err_flags[0]))
		else $error("channel 0 flags changed by a reserved clear bit");

	// channel 1 parity clear
	AST_CLEAR_PARITY: assert property (@(posedge clk) disable iff (!reset_n)
		wr_clr1 && wdata[`BIT_PARITY_CLR] && !ev[1].err_parity |=> !err_flags[1].parity)
		else $error("parity flag not cleared");

	// channel 1 framing clear
	AST_CLEAR_FRAME: assert property (@(posedge clk) disable iff (!reset_n)
		wr_clr1 && wdata[`BIT_FRAME_CLR] && !ev[1].err_frame |=> !err_flags[1].frame)
		else $error("framing flag not cleared");

	// channel 1 biphase framing clear
	AST_CLEAR_BIPHASE: assert property (@(posedge clk) disable iff (!reset_n)
		wr_clr1 && wdata[`BIT_BIPHASE_CLR] && !ev[1].err_biphase |=> !err_flags[1].biphase)
		else $error("biphase flag not cleared");

	// both clear registers read as zero
	AST_CLEAR_READ_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
		rd && (hit(addr, `ADDR_FLAG_CLEAR0) || hit(addr, `ADDR_FLAG_CLEAR1)) |=> rdata == 16'h0000)
		else $error("flag clear register read not zero");

	// stop trigger reads as zero
	AST_STOP_READ_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
		rd && hit(addr, `ADDR_STOP_TRIG) |=> rdata == 16'h0000)
		else $error("stop trigger read not zero");

	// a start during a transfer suspends it into wait
	AST_START_WAIT: assert property (@(posedge clk) disable iff (!reset_n)
		wr_start && wdata[1] |=> !chan_running[1])
		else $error("start trigger did not suspend channel 1");

	// a start keeps every error flag
	AST_START_KEEPS_FLAGS: assert property (@(posedge clk) disable iff (!reset_n)
		wr_start && ev == '0 |=> $stable(err_flags))
		else $error("error flags changed by start trigger");

	// a stop keeps every error flag
	AST_STOP_KEEPS_FLAGS: assert property (@(posedge clk) disable iff (!reset_n)
		wr_stop && ev == '0 |=> $stable(err_flags))
		else $error("error flags changed by stop trigger");

	// a stop ends the transfer of its channel
	AST_STOP_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
		wr_stop && wdata[0] |=> !chan_running[0])
		else $error("stop trigger left channel 0 running");

	// no channel runs while its enable state is low
	AST_RUN_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (!reset_n)
		(chan_running & ~chan_enabled) == 2'b00)
		else $error("channel running while disabled");

	// with output disabled a software write lands in the value bit
	AST_VALUE_SOFT: assert property (@(posedge clk) disable iff (!reset_n)
		wr && hit(addr, `ADDR_OUT_VALUE) && !s_q.out_enable |=> s_q.out_value == $past(wdata[0]))
		else $error("value bit write lost while output disabled");

	// with output enabled the pin shows engine data through the invert bit
	AST_PIN_INVERT: assert property (@(posedge clk) disable iff (!reset_n)
		s_q.out_enable |-> bus_transmit_pin == (s_q.out_value ^ s_q.out_invert))
		else $error("pin not inverted while output enabled");

	// fixed ones and zeros of the output value register
	AST_VALUE_FIXED_BITS: assert property (@(posedge clk) disable iff (!reset_n)
		rd && hit(addr, `ADDR_OUT_VALUE) |=> rdata[15:12] == 4'h0 && rdata[9:8] == 2'h3 && rdata[7:4] == 4'h0 && rdata[1])
		else $error("output value fixed bits wrong");

	// enable state reads back as held in the cycle of the strobe
	AST_ENABLE_READ: assert property (@(posedge clk) disable iff (!reset_n)
		rd && hit(addr, `ADDR_ENABLE_STATE) |=> rdata == {14'h0000, $past(chan_enabled)})
		else $error("enable state read wrong");

endmodule

// File: dv/serial_peer.sv
// serial peer model that drives the receive line of the block
`timescale 1ns/100ps
module serial_peer #(
	parameter int BIT_CYCLES = 8
) (
	input  wire logic clk,    // system clock
	output logic      rx_line // receive line, pulled up when idle
);
	// idle line sits at the pull-up level
	initial rx_line = 1'b1;
	// start bit held one full bit time; a slow bit keeps standby wake safe
	task automatic start_bit();
		@(posedge clk) rx_line <= 1'b0;
		repeat (BIT_CYCLES) @(posedge clk);
		rx_line <= 1'b1;
	endtask
endmodule

// File: dv/testbench.sv
// self-checking bench of the serial channel control block
`timescale 1ns/100ps
`include "serial_channel_control_regs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench
	import serial_channel_control_pkg::*;
;
	logic              clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic              tx_data = 1'b1, stop_mode = 1'b0, false_start = 1'b0;
	logic       [19:0] addr = '0;
	logic       [15:0] wdata = '0, rdata;
	chan_event_t [1:0] ev = '0;
	logic              rx_pin, bus_transmit_pin, rx_wake, clk_req, rx_error_irq;
	logic        [1:0] chan_enabled, chan_running;
	err_flags_t  [1:0] err_flags;
	int                err_total = 0, compares = 0, irq_cnt = 0, i;

	always #25 clk = ~clk;
	// interrupt pulses last one cycle, so count them at every edge
	always @(posedge clk) if (rx_error_irq === 1'b1) irq_cnt++;

	serial_channel_control i_serial_channel_control (.clk(clk), .reset_n(reset_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ev(ev), .tx_data(tx_data), .rx_pin(rx_pin),
		.stop_mode(stop_mode), .false_start(false_start), .chan_enabled(chan_enabled),
		.chan_running(chan_running), .err_flags(err_flags), .bus_transmit_pin(bus_transmit_pin),
		.rx_wake(rx_wake), .clk_req(clk_req), .rx_error_irq(rx_error_irq));
	serial_peer i_serial_peer (.clk(clk), .rx_line(rx_pin));

	task automatic end_of_test();
		if (err_total == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one-cycle write strobe, effects sampled just after the taking edge
	task automatic wr_reg(input logic [19:0] a, input logic [15:0] d);
		@(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
		@(posedge clk) wr <= 1'b0;
		#1;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [19:0] a, input logic [15:0] e);
		@(posedge clk) begin addr <= a; rd <= 1'b1; end
		@(posedge clk) rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	task automatic pulse(input int ch, input logic [5:0] m);
		@(posedge clk) ev[ch] <= chan_event_t'(m);
		@(posedge clk) ev <= '0;
		#1;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		end_of_test();
	end

	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		wait_n(1);
		`CHK(bus_transmit_pin, 1'b1)
		rd_reg(`ADDR_OUT_VALUE, `RESET_OUT_VALUE);
		rd_reg(`ADDR_ENABLE_STATE, `RESET_ZERO);
		rd_reg(20'hF05FE, `RESET_ZERO);
		// error flags set by the engines, cleared per channel
		pulse(0, 6'h02);
		pulse(1, 6'h0F);
		`CHK(err_flags[1], 4'hF)
		wr_reg(`ADDR_FLAG_CLEAR1, 16'h0000);
		`CHK(err_flags[1], 4'hF)
		wr_reg(`ADDR_FLAG_CLEAR0, 16'h0086);
		`CHK(err_flags[0], 4'h1)
		wr_reg(`ADDR_FLAG_CLEAR0, 16'h0087);
		`CHK(err_flags, {4'hF, 4'h0})
		rd_reg(`ADDR_FLAG_CLEAR0, `RESET_ZERO);
		// start both, suspend a running transfer, then stop channel 0
		// receive enable sits outside this block; four operating clocks pass before start
		wait_n(4);
		wr_reg(`ADDR_START_TRIG, 16'h0003);
		`CHK(chan_enabled, 2'b11)
		rd_reg(`ADDR_START_TRIG, `RESET_ZERO);
		rd_reg(`ADDR_ENABLE_STATE, 16'h0003);
		pulse(0, 6'h20);
		pulse(1, 6'h20);
		`CHK(chan_running, 2'b11)
		wr_reg(`ADDR_START_TRIG, 16'h0002);
		`CHK(chan_running, 2'b01)
		`CHK(err_flags[1], 4'hF)
		wr_reg(`ADDR_ENABLE_STATE, 16'h0000);
		`CHK(chan_enabled, 2'b11)
		wr_reg(`ADDR_STOP_TRIG, 16'h0001);
		`CHK(chan_enabled, 2'b10)
		`CHK(chan_running, 2'b00)
		rd_reg(`ADDR_STOP_TRIG, `RESET_ZERO);
		`CHK(err_flags[1], 4'hF)
		for (i = 0; i < 4; i++) begin
			wr_reg(`ADDR_FLAG_CLEAR1, 16'h0001 << ((i == 3) ? 7 : i));
			`CHK(err_flags[1], 4'(8'h0F << (i + 1)))
		end
		// output path: software value, engine data, inversion
		wr_reg(`ADDR_OUT_VALUE, 16'h0000);
		wait_n(2);
		`CHK(bus_transmit_pin, 1'b0)
		rd_reg(`ADDR_OUT_VALUE, `OUT_VALUE_FIXED1);
		wr_reg(`ADDR_OUT_VALUE, 16'h0001);
		wr_reg(`ADDR_OUT_ENABLE, 16'h0001);
		rd_reg(`ADDR_OUT_ENABLE, 16'h0001);
		@(posedge clk) tx_data <= 1'b0;
		wait_n(2);
		`CHK(bus_transmit_pin, 1'b0)
		wr_reg(`ADDR_OUT_INVERT, 16'h0001);
		rd_reg(`ADDR_OUT_INVERT, 16'h0001);
		wait_n(2);
		`CHK(bus_transmit_pin, 1'b1)
		@(posedge clk) tx_data <= 1'b1;
		wait_n(2);
		`CHK(bus_transmit_pin, 1'b0)
		wr_reg(`ADDR_OUT_VALUE, 16'h0000);
		rd_reg(`ADDR_OUT_VALUE, `RESET_OUT_VALUE);
		wr_reg(`ADDR_OUT_ENABLE, 16'h0000);
		wait_n(2);
		`CHK(bus_transmit_pin, 1'b1)
		// standby wake, error interrupt select and clock request
		@(posedge clk) stop_mode <= 1'b1;
		i_serial_peer.start_bit();
		wait_n(4);
		`CHK(rx_wake, 1'b0)
		wr_reg(`ADDR_STANDBY_CTRL, 16'h0001);
		i_serial_peer.start_bit();
		wait_n(4);
		`CHK({rx_wake, clk_req}, 2'b11)
		pulse(1, 6'h04);
		wait_n(3);
		`CHK(irq_cnt, 1)
		@(posedge clk) false_start <= 1'b1;
		@(posedge clk) false_start <= 1'b0;
		wait_n(3);
		`CHK(clk_req, 1'b0)
		i_serial_peer.start_bit();
		wr_reg(`ADDR_STANDBY_CTRL, 16'h0003);
		rd_reg(`ADDR_STANDBY_CTRL, 16'h0003);
		wait_n(4);
		`CHK(clk_req, 1'b1)
		pulse(1, 6'h08);
		wait_n(3);
		`CHK(irq_cnt, 1)
		`CHK(clk_req, 1'b0)
		i_serial_peer.start_bit();
		wait_n(4);
		wr_reg(`ADDR_STANDBY_CTRL, 16'h0000);
		wait_n(2);
		`CHK(clk_req, 1'b0)
		end_of_test();
	end
endmodule
